// file: hdl/lbu_top.sv
// Notes on behaviour
// - eight 4-bit waits, N means N+1 periods
// - symmetric: selector is duty bits 7:5
// - asymmetric: falling flag, then duty 7:6
// - writes go to shadow, commit at period end
// - reads return active value, not shadow
// - register at 10h, selector n nibble n
`timescale 1ns/1ps
module lbu_top (
    // clock and main_well_reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // engine side, same clock
    input wire logic period_end,
    input wire logic [lbu_pkg::LBU_DUTY_W-1:0] duty_cycle,
    input wire logic ramp_falling,
    output logic duty_update,
    output logic [2:0] segment_index
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] gaps_r, gaps_nxt;     // active interval fields
    logic [31:0] shadow_r, shadow_nxt; // pending write copy
    logic pend_r, pend_nxt;            // shadow holds an uncommitted write
    logic [1:0] ctrl_r, ctrl_nxt;      // symmetric select and commit allow
    logic [4:0] cnt_r, cnt_nxt;        // periods since last update
    logic upd_r, upd_nxt;              // registered update pulse
    logic [2:0] seg_r, seg_nxt;        // registered selector
    logic [31:0] rdata_r, rdata_nxt;   // registered read data
    lbu_pkg::lbu_sel_type sel;         // live decode
    logic wr_acc, rd_acc;              // write access and read setup strobes
    logic hit;                         // mapped address

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // writes act in the access phase, where pready is already high
    assign wr_acc = psel && penable && pwrite;
    // read data is latched in setup so it already stands in the access phase
    assign rd_acc = psel && !penable && !pwrite; // capture read data at setup
    // three words decode; every other offset is refused
    assign hit = (paddr == lbu_pkg::LBU_GAPS_OFS) || (paddr == lbu_pkg::LBU_CTRL_OFS)
        || (paddr == lbu_pkg::LBU_STAT_OFS);
    // zero wait states; unmapped access gets an error answer
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    // data outputs come straight from flip-flops, so the pins never glitch
    assign prdata = rdata_r;
    assign duty_update = upd_r;
    assign segment_index = seg_r;

    // ------------------------------------------------------------------
    // segment decode
    // ------------------------------------------------------------------
    // the decode is live, so a segment change mid-count meets the new wait
    lbu_seg_sel lbu_seg_sel_inst (
        .sym_sel(ctrl_r[lbu_pkg::LBU_CTRL_SYM]),
        .falling(ramp_falling),
        .duty(duty_cycle),
        .gaps(gaps_r),
        .sel(sel)
    );

    // ------------------------------------------------------------------
    // registers and counting
    // ------------------------------------------------------------------
    // next-state logic for the register file and period counter
    always_comb begin
        // hold by default, the selector tracks the decode; the update pulse lasts a single cycle
        gaps_nxt = gaps_r;
        shadow_nxt = shadow_r;
        pend_nxt = pend_r;
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        upd_nxt = 1'b0;
        seg_nxt = sel.seg;
        rdata_nxt = rdata_r;
        // a pending shadow moves only on a period boundary with commit allowed
        if (period_end && pend_r && ctrl_r[lbu_pkg::LBU_CTRL_ALLOW]) begin
            gaps_nxt = shadow_r;
            pend_nxt = 1'b0;
        end
        // a write in the commit cycle re-arms pending, so it is not lost
        if (wr_acc && paddr == lbu_pkg::LBU_GAPS_OFS) begin
            shadow_nxt = pwdata;
            pend_nxt = 1'b1;
        end
        // control word: symmetric select and commit allow
        if (wr_acc && paddr == lbu_pkg::LBU_CTRL_OFS) begin
            ctrl_nxt = pwdata[1:0];
        end
        // the word then stands on prdata until the next read setup
        if (rd_acc) begin
            unique case (paddr)
                lbu_pkg::LBU_GAPS_OFS: rdata_nxt = gaps_r;
                lbu_pkg::LBU_CTRL_OFS: rdata_nxt = {30'h0000_0000, ctrl_r};
                lbu_pkg::LBU_STAT_OFS: rdata_nxt = {23'h00_0000, pend_r, cnt_r, seg_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // count whole periods; wait N means update after N+1 of them
        if (period_end) begin
            if (cnt_r + 5'h01 >= {1'b0, sel.wait_cnt} + 5'h01) begin
                cnt_nxt = 5'h00;
                upd_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
    end

    // registering only
    // reset restores every field to its default value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gaps_r <= lbu_pkg::LBU_GAPS_RST;
            shadow_r <= lbu_pkg::LBU_GAPS_RST;
            pend_r <= 1'b0;
            ctrl_r <= lbu_pkg::LBU_CTRL_RST;
            cnt_r <= 5'h00;
            upd_r <= 1'b0;
            seg_r <= 3'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            gaps_r <= gaps_nxt;
            shadow_r <= shadow_nxt;
            pend_r <= pend_nxt;
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            upd_r <= upd_nxt;
            seg_r <= seg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // a zero wait count updates after a single period
    wait_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && sel.wait_cnt == 4'h0 |=> duty_update)
        else $error("wait 0 did not update after one period");

    // a boundary that meets the selected wait count raises the pulse
    wait_reached_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && cnt_r == {1'b0, sel.wait_cnt} |=> duty_update)
        else $error("update missing when wait count reached");

    // symmetric mode: selector follows the top three duty bits
    sym_index_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[lbu_pkg::LBU_CTRL_SYM]
        |=> segment_index == $past(duty_cycle[lbu_pkg::LBU_SYM_HI:lbu_pkg::LBU_SYM_LO]))
        else $error("symmetric selector wrong");

    // asymmetric mode: ramp direction on top, then two duty bits
    asym_index_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[lbu_pkg::LBU_CTRL_SYM] |=> segment_index
        == {$past(ramp_falling), $past(duty_cycle[lbu_pkg::LBU_SYM_HI:lbu_pkg::LBU_ASY_LO])})
        else $error("asymmetric selector wrong");

    // outside a permitted boundary the active copy never moves
    no_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(period_end && ctrl_r[lbu_pkg::LBU_CTRL_ALLOW]) |=> $stable(gaps_r))
        else $error("active interval changed outside a commit");

    // a permitted boundary with a pending write commits the shadow
    do_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && pend_r && ctrl_r[lbu_pkg::LBU_CTRL_ALLOW] |=> gaps_r == $past(shadow_r))
        else $error("shadow not committed");

    // a commit with no fresh write leaves nothing pending
    commit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && pend_r && ctrl_r[lbu_pkg::LBU_CTRL_ALLOW]
        && !(wr_acc && paddr == lbu_pkg::LBU_GAPS_OFS) |=> !pend_r)
        else $error("pending flag kept after commit");

    // an interval write lands in the shadow and marks it pending
    shadow_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == lbu_pkg::LBU_GAPS_OFS |=> shadow_r == $past(pwdata) && pend_r)
        else $error("interval write not held in shadow");

    // software sees the copy the engine uses, never the shadow
    read_active_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == lbu_pkg::LBU_GAPS_OFS |=> prdata == $past(gaps_r))
        else $error("read did not return active value");

    // selector 111b reads the top nibble
    nibble_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel.seg == 3'h7 |-> sel.wait_cnt == gaps_r[31:28])
        else $error("selector 7 not mapped to top nibble");

    // selector 000b reads the lowest nibble
    nibble_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel.seg == 3'h0 |-> sel.wait_cnt == gaps_r[lbu_pkg::LBU_FLD_W-1:0])
        else $error("selector 0 not mapped to bottom nibble");

    // an update always starts a fresh count
    count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        duty_update |-> cnt_r == 5'h00)
        else $error("count not restarted on update");

    // the count never passes the largest wait
    count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_r <= 5'h0f)
        else $error("count exceeded sixteen periods");

    // between boundaries the count and the pulse stay quiet
    count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !period_end |=> $stable(cnt_r) && !duty_update)
        else $error("count moved or update pulsed without a period end");

    // below the wait count a boundary only advances the count
    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && cnt_r < {1'b0, sel.wait_cnt}
        |=> !duty_update && cnt_r == $past(cnt_r) + 5'h01)
        else $error("count did not advance by one period");
endmodule : lbu_top

// file: hdl/lbu_pkg.sv
package lbu_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] LBU_GAPS_OFS = 12'h010; // breath_segment_gaps
    localparam logic [11:0] LBU_CTRL_OFS = 12'h014; // control bits
    localparam logic [11:0] LBU_STAT_OFS = 12'h018; // engine status
    localparam logic [31:0] LBU_GAPS_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int LBU_SEGS = 8;       // number of segment fields
    localparam int LBU_FLD_W = 4;      // width of one wait count field
    localparam int LBU_DUTY_W = 8;     // duty cycle bits seen by the selector
    localparam int LBU_SYM_HI = 7;     // symmetric selector top duty bit
    localparam int LBU_SYM_LO = 5;     // symmetric selector low duty bit
    localparam int LBU_ASY_LO = 6;     // asymmetric selector low duty bit
    localparam int LBU_CTRL_SYM = 0;   // ctrl bit: ramp_symmetric_select
    localparam int LBU_CTRL_ALLOW = 1; // ctrl bit: shadow commit allow
    localparam logic [1:0] LBU_CTRL_RST = 2'h0;

    // selector and count pair from the segment decode
    typedef struct packed {
        logic [2:0] seg;
        logic [LBU_FLD_W-1:0] wait_cnt;
    } lbu_sel_type;

endpackage : lbu_pkg

// file: hdl/lbu_seg_sel.sv
`timescale 1ns/1ps
module lbu_seg_sel (
    // configuration
    input wire logic sym_sel,
    input wire logic falling,
    input wire logic [lbu_pkg::LBU_DUTY_W-1:0] duty,
    input wire logic [31:0] gaps,
    // decoded selection
    output lbu_pkg::lbu_sel_type sel
);
    // ------------------------------------------------------------------
    // segment decode
    // ------------------------------------------------------------------
    always_comb begin
        if (sym_sel) begin
            sel.seg = duty[lbu_pkg::LBU_SYM_HI:lbu_pkg::LBU_SYM_LO];
        end else begin
            sel.seg = {falling, duty[lbu_pkg::LBU_SYM_HI:lbu_pkg::LBU_ASY_LO]};
        end
        // selector n picks nibble n, 111b the top one
        sel.wait_cnt = gaps[sel.seg*lbu_pkg::LBU_FLD_W +: lbu_pkg::LBU_FLD_W];
    end
endmodule : lbu_seg_sel

// file: testbench/lbu_top_tb.sv
`timescale 1ns/1ps
module lbu_top_tb;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0; // held low for five cycles
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic period_end = 1'b0; // one-cycle pulse per pwm period
    logic [7:0] duty_cycle = 8'h00;
    logic ramp_falling = 1'b0;
    logic duty_update;
    logic [2:0] segment_index;
    int miscompares = 0;
    int cmp_count = 0;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    lbu_top lbu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .period_end(period_end), .duty_cycle(duty_cycle),
        .ramp_falling(ramp_falling), .duty_update(duty_update), .segment_index(segment_index));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // counted compare; four-state so an unknown never matches
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // one apb transfer; waits for pready under a bound, never a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        // the bound ran out without an answer: count it and close the run
        if (pready !== 1'b1) begin
            check(0, 1, "apb timeout");
            finish_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one period_end pulse of one cycle, then drops it; reports the update pulse 1 ns later
    task automatic pulse(output logic upd);
        @(posedge pclk);
        period_end <= 1'b1;
        @(posedge pclk);
        period_end <= 1'b0;
        #1 upd = duty_update;
    endtask : pulse
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // shadow write held back until commits are allowed, reads show active copy
    task automatic t_shadow;
        logic [31:0] q;
        logic e;
        logic u;
        apb(0, lbu_pkg::LBU_GAPS_OFS, 0, q, e);
        check(q, lbu_pkg::LBU_GAPS_RST, "gaps reset");
        apb(1, lbu_pkg::LBU_GAPS_OFS, 32'hF654_3210, q, e);
        apb(0, lbu_pkg::LBU_GAPS_OFS, 0, q, e);
        check(q, 32'h0000_0000, "shadow read");
        check({31'h0, e}, 0, "mapped access error");
        apb(0, lbu_pkg::LBU_STAT_OFS, 0, q, e);
        check({31'h0, q[8]}, 1, "shadow pending");
        pulse(u);
        apb(0, lbu_pkg::LBU_GAPS_OFS, 0, q, e);
        check(q, 32'h0000_0000, "blocked commit");
        apb(1, lbu_pkg::LBU_CTRL_OFS, 32'h0000_0002, q, e);
        apb(0, lbu_pkg::LBU_CTRL_OFS, 0, q, e);
        check(q, 32'h0000_0002, "control readback");
        pulse(u);
        apb(0, lbu_pkg::LBU_GAPS_OFS, 0, q, e);
        check(q, 32'hF654_3210, "commit");
        apb(0, 12'h020, 0, q, e);
        check({31'h0, e}, 1, "unmapped");
        check(q, 32'h0000_0000, "unmapped data");
    endtask : t_shadow
    // every segment: selector decode and n+1 periods between updates
    task automatic t_seg(input logic sym);
        logic [31:0] q;
        logic e;
        logic u;
        int n;
        apb(1, lbu_pkg::LBU_CTRL_OFS, {30'h0, 1'b1, sym}, q, e);
        for (int s = 0; s < 8; s++) begin
            @(posedge pclk);
            // the unused input is set opposite so a wrong decode shows
            if (sym) duty_cycle <= {s[2:0], 5'h15};
            else duty_cycle <= {s[1:0], ~s[2], 5'h0A};
            ramp_falling <= sym ? ~s[0] : s[2];
            repeat (2) @(posedge pclk);
            #1 check(segment_index, s, "segment");
            n = 0;
            // flush a count begun under the previous segment
            do begin
                pulse(u);
                n++;
            end while (u !== 1'b1 && n < 20);
            if (u !== 1'b1) begin
                check(0, 1, "flush timeout");
                finish_test();
            end
            n = 0;
            do begin
                pulse(u);
                n++;
            end while (u !== 1'b1 && n < 20);
            check(n, (s == 7) ? 16 : s + 1, "periods");
        end
    endtask : t_seg
    // mid-run reset returns outputs and registers to their defaults
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 check({31'h0, duty_update}, 0, "update in reset");
        check({29'h0, segment_index}, 0, "index in reset");
        check(prdata, 32'h0000_0000, "read data in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, lbu_pkg::LBU_GAPS_OFS, 0, q, e);
        check(q, lbu_pkg::LBU_GAPS_RST, "gaps after reset");
        apb(0, lbu_pkg::LBU_CTRL_OFS, 0, q, e);
        check(q, 32'h0000_0000, "control after reset");
    endtask : t_reset
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_shadow();
        t_seg(1'b1);
        t_seg(1'b0);
        t_reset();
        finish_test();
    end
endmodule : lbu_top_tb
